// >>> rtl/vmsad_pkg.sv
package vmsad_pkg;

   // =====================================================================
   // Address modifier codes
   localparam logic [5:0] AM_A24_SUP_BLT  = 6'h3F;
   localparam logic [5:0] AM_A24_SUP_DATA = 6'h3D;
   localparam logic [5:0] AM_A24_SUP_MBLT = 6'h3C;
   localparam logic [5:0] AM_A24_USR_BLT  = 6'h3B;
   localparam logic [5:0] AM_A24_USR_DATA = 6'h39;
   localparam logic [5:0] AM_A24_USR_MBLT = 6'h38;
   localparam logic [5:0] AM_CR_CSR       = 6'h2F;
   localparam logic [5:0] AM_A32_SUP_BLT  = 6'h0F;
   localparam logic [5:0] AM_A32_SUP_DATA = 6'h0D;
   localparam logic [5:0] AM_A32_SUP_MBLT = 6'h0C;
   localparam logic [5:0] AM_A32_USR_BLT  = 6'h0B;
   localparam logic [5:0] AM_A32_USR_DATA = 6'h09;
   localparam logic [5:0] AM_A32_USR_MBLT = 6'h08;

   // =====================================================================
   // Address map inside the board window
   localparam logic [15:0] BUF_LAST_OFS   = 16'h07FC;  // Buffer 0x0000..0x07FC
   localparam logic [7:0]  MCST_RST_VAL   = 8'hAA;
   localparam logic [7:0]  ADER_RST_VAL   = 8'h00;
   localparam int          SEL_BIT        = 4;
   localparam logic [2:0]  IRQ_LVL_OFF    = 3'h0;
   localparam logic [1:0]  IND_HOLD_CYC   = 2'h3;

   // =====================================================================
   // Cycle classes
   typedef enum logic [2:0] {
      VMSAD_CYC_NONE = 3'b000,
      VMSAD_CYC_REG  = 3'b001,
      VMSAD_CYC_BUF  = 3'b010,
      VMSAD_CYC_CSR  = 3'b011,
      VMSAD_CYC_MCST = 3'b100,
      VMSAD_CYC_CBLT = 3'b101
   } vmsad_cyc_t;

endpackage : vmsad_pkg

// >>> rtl/vmsad_sync.sv
`timescale 1ns/10ps
`default_nettype none
module vmsad_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_resetn,
   // Data
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule : vmsad_sync
`default_nettype wire

// >>> rtl/vmsad_top.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Accept A24 single, block and 64-bit block cycles, supervisory and user.
// - Accept A32 single, block and 64-bit block cycles, supervisory and user.
// - Base anywhere on 64 KB boundary; only upper address bits compared.
// - Selection bit 4 clear after reset: base from rotary switches.
// - Selection bit 4 set: base from programmable base registers.
// - Upper base register gives A31..A24, lower gives A23..A16.
// - Four rotary digits form the switch base address.
// - Board answers on own base and shared multicast/chain address.
// - A24, A32, geographic CR/CSR and multicast addressing supported.
// - Registers take 16-bit access, 32-bit where register allows.
// - Buffer readable by D32, BLT32, MBLT64, chained 32-bit block transfers.
// - Release-on-access interrupter requests on any of seven levels.
// - Access indicator pulses on every completed access, from acknowledge.
// - Multicast and chained cycles are A32 only with four modifier codes.
// - Registers take single cycles, multicast writes also block cycles, chained reads block cycles only; 64-bit block mode only for the buffer.
// - Interrupt acknowledge returns 8-bit status/ID on low data lines.
// - Request withdrawn when buffer read drops event count below trigger.
module vmsad_top
   import vmsad_pkg::*;
#(
   parameter int EVW = 6
) (
   // Clock and reset
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_resetn,
   // VME address phase (asynchronous bus)
   input  wire logic                 i_as_n,
   input  wire logic [5:0]           i_am,
   input  wire logic [31:1]          i_addr,
   input  wire logic                 i_lword_n,
   input  wire logic                 i_ds0_n,
   input  wire logic                 i_ds1_n,
   input  wire logic                 i_write_n,
   input  wire logic                 i_iack_n,
   input  wire logic                 i_iackin_n,
   input  wire logic [4:0]           i_geo_addr,
   input  wire logic [15:0]          i_rotary,
   // Configuration from the board's register block
   input  wire logic                 i_base_sel,
   input  wire logic [7:0]           i_ader_high,
   input  wire logic [7:0]           i_ader_low,
   input  wire logic [7:0]           i_mcst_addr,
   input  wire logic [1:0]           i_chain_pos,
   input  wire logic [2:0]           i_irq_level,
   input  wire logic [7:0]           i_irq_vector,
   input  wire logic [EVW-1:0]       i_event_trig,
   input  wire logic [EVW-1:0]       i_event_count,
   input  wire logic                 i_access_done,
   // Decode results
   output logic                      o_sel,
   output vmsad_pkg::vmsad_cyc_t     o_cyc,
   output logic                      o_wide,
   output logic                      o_block,
   output logic                      o_mblt,
   output logic [15:0]               o_offset,
   // Interrupter
   output logic [7:1]                o_irq_n,
   output logic                      o_iack_sel,
   output logic [7:0]                o_iack_data,
   // Acknowledge and indicator
   output logic                      o_access_indicator_n,
   output logic                      o_access_indicator
);
   // =====================================================================
   // Input synchronisers
   logic [5:0]  am_s;
   logic [31:1] addr_s;
   logic        as_n_s, ds0_n_s, ds1_n_s, ds_n_s, write_n_s;
   logic        iack_n_s, iackin_n_s, lword_n_s;
   logic [15:0] rot_s;
   logic [4:0]  geo_s;
   // Each strobe synchronised alone; gating raw pins first could glitch
   vmsad_sync #(.W(44)) u_sync_bus (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .i_async   ({i_am, i_addr, i_as_n, i_ds0_n, i_ds1_n, i_write_n, i_iack_n,
                   i_iackin_n, i_lword_n}),
      .o_sync    ({am_s, addr_s, as_n_s, ds0_n_s, ds1_n_s, write_n_s, iack_n_s,
                   iackin_n_s, lword_n_s})
   );
   assign ds_n_s = ds0_n_s & ds1_n_s;
   vmsad_sync #(.W(21)) u_sync_cfg (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .i_async   ({i_rotary, i_geo_addr}),
      .o_sync    ({rot_s, geo_s})
   );

   // =====================================================================
   // Address phase decode
   logic        as_prev_q, as_fall;
   logic        is_a24, is_a32, is_csr, is_blk, is_mblt, is_mcst_am;
   logic [7:0]  base_hi, base_lo;
   logic        hit_a24, hit_a32, hit_mcst, hit_csr;
   vmsad_cyc_t  cyc_d;
   assign as_fall = as_prev_q & ~as_n_s;
   always_comb begin
      {is_a24, is_a32, is_csr, is_blk, is_mblt} = 5'h00;
      unique case (am_s)
         AM_A24_SUP_BLT, AM_A24_USR_BLT:   {is_a24, is_blk}  = 2'h3;
         AM_A24_SUP_DATA, AM_A24_USR_DATA: is_a24            = 1'b1;
         AM_A24_SUP_MBLT, AM_A24_USR_MBLT: {is_a24, is_mblt} = 2'h3;
         AM_A32_SUP_BLT, AM_A32_USR_BLT:   {is_a32, is_blk}  = 2'h3;
         AM_A32_SUP_DATA, AM_A32_USR_DATA: is_a32            = 1'b1;
         AM_A32_SUP_MBLT, AM_A32_USR_MBLT: {is_a32, is_mblt} = 2'h3;
         AM_CR_CSR:                        is_csr            = 1'b1;
         default: ;
      endcase
   end
   // Chained/multicast: A32 block or single only, no 64-bit block codes
   assign is_mcst_am = is_a32 & ~is_mblt;
   // Base source chosen per address phase; a switch flip mid-cycle cannot tear
   assign base_hi = i_base_sel ? i_ader_high : rot_s[15:8];
   assign base_lo = i_base_sel ? i_ader_low  : rot_s[7:0];
   // Only A31..A16 compared, so base sits on 64 KB boundaries
   assign hit_a24  = is_a24 & (addr_s[23:16] == base_lo);
   assign hit_a32  = is_a32 & (addr_s[31:24] == base_hi)
                     & (addr_s[23:16] == base_lo);
   assign hit_mcst = is_mcst_am & (addr_s[31:24] == i_mcst_addr)
                     & (i_chain_pos != 2'b00) & ~iackin_n_s;
   assign hit_csr  = is_csr & (addr_s[23:19] == geo_s);
   always_comb begin
      cyc_d = VMSAD_CYC_NONE;
      if (!iack_n_s) begin
         cyc_d = VMSAD_CYC_NONE;
      end else if (hit_a24 || hit_a32) begin
         cyc_d = (addr_s[15:1] <= BUF_LAST_OFS[15:1]) ? VMSAD_CYC_BUF
                                                        : VMSAD_CYC_REG;
      end else if (hit_mcst) begin
         cyc_d = write_n_s ? VMSAD_CYC_CBLT : VMSAD_CYC_MCST;
      end else if (hit_csr) begin
         cyc_d = VMSAD_CYC_CSR;
      end
   end

   // =====================================================================
   // Cycle state
   logic        sel_d, sel_q, wide_d, wide_q, block_d, block_q, mblt_d, mblt_q;
   logic [15:0] ofs_d, ofs_q;
   vmsad_cyc_t  cyc_n, cyc_q;
   always_comb begin
      sel_d   = sel_q;
      cyc_n   = cyc_q;
      wide_d  = wide_q;
      block_d = block_q;
      mblt_d  = mblt_q;
      ofs_d   = ofs_q;
      if (as_n_s) begin
         sel_d = 1'b0;
         cyc_n = VMSAD_CYC_NONE;
      end else if (as_fall) begin
         cyc_n = cyc_d;
         // Block and 64-bit block modes not for registers, and chained reads need block mode, else the cycle is ignored
         if (cyc_d == VMSAD_CYC_REG && (is_blk || is_mblt)) begin
            cyc_n = VMSAD_CYC_NONE;
         end
         if ((cyc_d == VMSAD_CYC_CBLT) && !(is_blk)) begin
            cyc_n = VMSAD_CYC_NONE;
         end
         sel_d   = (cyc_n != VMSAD_CYC_NONE);
         wide_d  = ~lword_n_s | is_mblt;
         block_d = is_blk | is_mblt;
         mblt_d  = is_mblt;
         ofs_d   = {addr_s[15:1], 1'b0};
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         as_prev_q <= 1'b1;
         sel_q     <= 1'b0;
         cyc_q     <= VMSAD_CYC_NONE;
         wide_q    <= 1'b0;
         block_q   <= 1'b0;
         mblt_q    <= 1'b0;
         ofs_q     <= 16'h0000;
      end else begin
         as_prev_q <= as_n_s;
         sel_q     <= sel_d;
         cyc_q     <= cyc_n;
         wide_q    <= wide_d;
         block_q   <= block_d;
         mblt_q    <= mblt_d;
         ofs_q     <= ofs_d;
      end
   end
   assign o_sel    = sel_q;
   assign o_cyc    = cyc_q;
   assign o_wide   = wide_q;
   assign o_block  = block_q;
   assign o_mblt   = mblt_q;
   assign o_offset = ofs_q;

   // =====================================================================
   // Release-on-access interrupter
   logic [7:1] irq_n_d, irq_n_q;
   logic       irq_on, iack_sel_d, iack_sel_q;
   logic [7:0] iack_data_d, iack_data_q;
   // Level 0 or trigger 0 disables; drops once reads bring count below trigger
   assign irq_on = (i_irq_level != IRQ_LVL_OFF) && (i_event_trig != '0)
                   && (i_event_count >= i_event_trig);

   always_comb begin
      irq_n_d = '1;
      if (irq_on) begin
         irq_n_d[i_irq_level] = 1'b0;
      end
      iack_sel_d  = iack_sel_q;
      iack_data_d = iack_data_q;
      if (as_n_s) begin
         iack_sel_d = 1'b0;
      end else if (as_fall && !iack_n_s) begin
         // Responds to acknowledge of its own level with daisy token held
         iack_sel_d  = irq_on && (addr_s[3:1] == i_irq_level) && !iackin_n_s;
         iack_data_d = i_irq_vector;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_n_q     <= '1;
         iack_sel_q  <= 1'b0;
         iack_data_q <= 8'h00;
      end else begin
         irq_n_q     <= irq_n_d;
         iack_sel_q  <= iack_sel_d;
         iack_data_q <= iack_data_d;
      end
   end

   assign o_irq_n     = irq_n_q;
   assign o_iack_sel  = iack_sel_q;
   assign o_iack_data = iack_data_q;

   // =====================================================================
   // Acknowledge and access indicator
   logic       access_indicator_n_d, access_indicator_n_q;
   logic       ind_d, ind_q;
   logic [1:0] ind_cnt_d, ind_cnt_q;
   always_comb begin
      access_indicator_n_d = access_indicator_n_q;
      if (as_n_s || ds_n_s) begin
         access_indicator_n_d = 1'b1;
      end else if ((sel_q || iack_sel_q) && i_access_done) begin
         access_indicator_n_d = 1'b0;
      end
      // Stretched a few cycles so the lamp driver sees even short cycles
      ind_cnt_d = ind_cnt_q;
      if (access_indicator_n_q && !access_indicator_n_d) begin
         ind_cnt_d = IND_HOLD_CYC;
      end else if (ind_cnt_q != 2'h0) begin
         ind_cnt_d = ind_cnt_q - 2'h1;
      end
      ind_d = (ind_cnt_d != 2'h0);
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         access_indicator_n_q <= 1'b1;
         ind_cnt_q <= 2'h0;
         ind_q     <= 1'b0;
      end else begin
         access_indicator_n_q <= access_indicator_n_d;
         ind_cnt_q <= ind_cnt_d;
         ind_q     <= ind_d;
      end
   end

   assign o_access_indicator_n          = access_indicator_n_q;
   assign o_access_indicator = ind_q;
endmodule : vmsad_top
`default_nettype wire

// >>> sim/vmsad_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ===================================================================
// Protocol checker on the decoder ports
module vmsad_checker
   import vmsad_pkg::*;
#(
   parameter int EVW = 6
) (
   // Clock and reset
   input wire logic                  i_clk_sys,
   input wire logic                  i_resetn,
   // Bus strobes
   input wire logic                  i_as_n,
   input wire logic                  i_ds0_n,
   input wire logic                  i_ds1_n,
   input wire logic                  i_iack_n,
   // Interrupter setup
   input wire logic [2:0]            i_irq_level,
   input wire logic [EVW-1:0]        i_event_trig,
   input wire logic [EVW-1:0]        i_event_count,
   // Decoder outputs
   input wire logic                  o_sel,
   input wire vmsad_pkg::vmsad_cyc_t o_cyc,
   input wire logic                  o_wide,
   input wire logic                  o_block,
   input wire logic                  o_mblt,
   input wire logic [7:1]            o_irq_n,
   input wire logic                  o_iack_sel,
   input wire logic                  o_access_indicator_n,
   input wire logic                  o_access_indicator
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   logic [7:0] irq_bit;
   logic [7:1] irq_exp_n;
   logic       req_on;
   assign irq_bit   = 8'h01 << i_irq_level;
   assign irq_exp_n = ~irq_bit[7:1];
   assign req_on    = (i_irq_level != 3'h0) && (i_event_trig != '0)
                      && (i_event_count >= i_event_trig);

   sequence ack_fall_s;
      $fell(o_access_indicator_n);
   endsequence
   sequence ind_hold_s;
      o_access_indicator [*3] ##1 !o_access_indicator;
   endsequence

   ack_cause_a: assert property (ack_fall_s |-> $past(o_sel | o_iack_sel))
      else $error("acknowledge without a decoded cycle");
   ind_pulse_a: assert property (ack_fall_s |-> ind_hold_s)
      else $error("indicator pulse length wrong");
   ind_cause_a: assert property ($rose(o_access_indicator) |-> ack_fall_s)
      else $error("indicator rose without acknowledge");
   sel_drop_a: assert property (i_as_n [*5] |-> !o_sel && o_cyc == VMSAD_CYC_NONE)
      else $error("select held after address strobe release");
   ack_drop_a: assert property ((i_ds0_n && i_ds1_n) [*5] |-> o_access_indicator_n)
      else $error("acknowledge held after data strobes release");
   iack_nosel_a: assert property (!i_iack_n [*6] |-> !o_sel)
      else $error("select during interrupt acknowledge");
   irq_set_a: assert property (req_on |=> o_irq_n == $past(irq_exp_n))
      else $error("interrupt request on wrong level");
   irq_clr_a: assert property (!req_on |=> &o_irq_n)
      else $error("interrupt request not withdrawn");
   mblt_wide_a: assert property (o_mblt |-> o_block && o_wide)
      else $error("64-bit block without block and wide");
   class_hold_a: assert property ($rose(o_sel) |-> o_cyc != VMSAD_CYC_NONE ##1 $stable(o_cyc))
      else $error("cycle class missing or unstable");
endmodule : vmsad_checker

bind vmsad_top vmsad_checker #(.EVW(EVW)) u_chk (.i_clk_sys, .i_resetn, .i_as_n, .i_ds0_n,
   .i_ds1_n, .i_iack_n, .i_irq_level, .i_event_trig, .i_event_count, .o_sel, .o_cyc,
   .o_wide, .o_block, .o_mblt, .o_irq_n, .o_iack_sel, .o_access_indicator_n, .o_access_indicator);
`default_nettype wire

// >>> sim/vmsad_master.sv
`timescale 1ns/10ps
`default_nettype none
// ===================================================================
// Bus master model, one cycle at a time
module vmsad_master (
   // Clock
   input  wire logic        i_clk_sys,
   // Strobes and address
   output var  logic        o_as_n,
   output var  logic        o_ds_n,
   output var  logic        o_write_n,
   output var  logic        o_iack_n,
   output var  logic        o_lword_n,
   output var  logic [5:0]  o_am,
   output var  logic [31:1] o_addr,
   // Acknowledge
   input  wire logic        i_access_indicator_n
);
   initial begin
      o_as_n    = 1'b1;
      o_ds_n    = 1'b1;
      o_write_n = 1'b1;
      o_iack_n  = 1'b1;
      o_lword_n = 1'b1;
      o_am      = 6'h15;
      o_addr    = 31'h2AAA_AAAA;
   end

   task automatic addr_phase(input logic [5:0] am, input logic [31:0] a,
                             input logic wr, input logic lw, input logic iack);
      @(posedge i_clk_sys);
      #1;
      o_am      = am;
      o_addr    = a[31:1];
      o_write_n = ~wr;
      o_lword_n = ~lw;
      o_iack_n  = ~iack;
      o_as_n    = 1'b0;
      repeat (6) @(posedge i_clk_sys);
      #1;
   endtask : addr_phase

   task automatic data_phase(output logic ack);
      int n;
      n      = 0;
      ack    = 1'b0;
      o_ds_n = 1'b0;
      while (n < 12 && !ack) begin
         @(posedge i_clk_sys);
         #1;
         ack = (i_access_indicator_n === 1'b0);
         n++;
      end
      o_ds_n = 1'b1;
      repeat (5) @(posedge i_clk_sys);
      // Released lines float, so show a changed value
      #1 o_as_n = 1'b1;
      o_am   = ~o_am;
      o_addr = ~o_addr;
      o_iack_n = 1'b1;
      repeat (5) @(posedge i_clk_sys);
      #1;
   endtask : data_phase
endmodule : vmsad_master
`default_nettype wire

// >>> sim/vmsad_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ===================================================================
// Decoder bench against a behavioural model
module vmsad_tb_top;
   import vmsad_pkg::*;
   logic        i_clk_sys     = 1'b0;
   logic        i_resetn      = 1'b0;
   logic        i_as_n, i_lword_n, ds_n, i_write_n, i_iack_n;
   logic [5:0]  i_am;
   logic [31:1] i_addr;
   logic        i_iackin_n    = 1'b1;
   logic [4:0]  i_geo_addr    = 5'h05;
   logic [15:0] i_rotary      = 16'h1234;
   logic        i_base_sel    = 1'b0;
   logic [7:0]  i_ader_high   = 8'h56;
   logic [7:0]  i_ader_low    = 8'h78;
   logic [7:0]  i_mcst_addr   = MCST_RST_VAL;
   logic [1:0]  i_chain_pos   = 2'h0;
   logic [2:0]  i_irq_level   = 3'h0;
   logic [7:0]  i_irq_vector  = 8'hC5;
   logic [5:0]  i_event_trig  = 6'h00;
   logic [5:0]  i_event_count = 6'h00;
   logic        i_access_done = 1'b0;
   logic        o_sel, o_wide, o_block, o_mblt, o_iack_sel, o_access_indicator_n, o_access_indicator;
   vmsad_cyc_t  o_cyc;
   logic [15:0] o_offset;
   logic [7:1]  o_irq_n;
   logic [7:0]  o_iack_data;
   logic [5:0]  mam [4] = '{AM_A32_SUP_DATA, AM_A32_USR_DATA, AM_A32_SUP_BLT, AM_A32_USR_BLT};
   int          num_errors = 0;
   int          tests_run  = 0;
   int          ind_rises  = 0;

   always #2.5 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) i_access_done <= #1 ~ds_n;
   always @(posedge o_access_indicator) ind_rises++;

   vmsad_top #(.EVW(6)) dut (.i_clk_sys, .i_resetn, .i_as_n, .i_am, .i_addr, .i_lword_n,
      .i_ds0_n(ds_n), .i_ds1_n(ds_n), .i_write_n, .i_iack_n, .i_iackin_n, .i_geo_addr,
      .i_rotary, .i_base_sel, .i_ader_high, .i_ader_low, .i_mcst_addr, .i_chain_pos,
      .i_irq_level, .i_irq_vector, .i_event_trig, .i_event_count, .i_access_done,
      .o_sel, .o_cyc, .o_wide, .o_block, .o_mblt, .o_offset, .o_irq_n, .o_iack_sel,
      .o_iack_data, .o_access_indicator_n, .o_access_indicator);
   vmsad_master u_mst (.i_clk_sys, .o_as_n(i_as_n), .o_ds_n(ds_n), .o_write_n(i_write_n),
      .o_iack_n(i_iack_n), .o_lword_n(i_lword_n), .o_am(i_am), .o_addr(i_addr),
      .i_access_indicator_n(o_access_indicator_n));

   // ================================================================
   // Model and checks
   function automatic int exp_cyc(input logic [5:0] am, input logic [31:0] a, input logic wr);
      logic [15:0] b;
      b = i_base_sel ? {i_ader_high, i_ader_low} : i_rotary;
      if (i_chain_pos != 2'h0 && !i_iackin_n && a[31:24] == i_mcst_addr
          && am[5:3] == 3'h1 && am[2:0] inside {3'h1, 3'h3, 3'h5, 3'h7})
         return am[1] ? (wr ? 0 : 5) : (wr ? 4 : 0);
      if (am == AM_CR_CSR) return (a[23:19] == i_geo_addr) ? 3 : 0;
      if (!(am[5:3] inside {3'h1, 3'h7}) || am[2:0] inside {3'h2, 3'h6}) return 0;
      if (am[5] ? a[23:16] != b[7:0] : a[31:16] != b) return 0;
      if (a[15:0] <= BUF_LAST_OFS) return 2;
      return (am[0] && !am[1]) ? 1 : 0;
   endfunction : exp_cyc

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   task automatic run_cycle(input logic [5:0] am, input logic [31:0] a,
                            input logic wr, input logic lw, input logic iack);
      int   ec, n0;
      logic ei, ack;
      ec = iack ? 0 : exp_cyc(am, a, wr);
      ei = iack && !i_iackin_n && a[3:1] == i_irq_level && i_irq_level != 3'h0
           && i_event_trig != 6'h00 && i_event_count >= i_event_trig;
      u_mst.addr_phase(am, a, wr, lw, iack);
      chk("sel", ec != 0, o_sel);
      chk("cyc", ec, o_cyc);
      chk("iack_sel", ei, o_iack_sel);
      if (ei) chk("iack_data", i_irq_vector, o_iack_data);
      if (ec != 0) begin
         chk("offset", {a[15:1], 1'b0}, o_offset);
         chk("block", am != AM_CR_CSR && !(am[0] && !am[1]), o_block);
         chk("mblt", am[1:0] == 2'h0, o_mblt);
         chk("wide", lw || am[1:0] == 2'h0, o_wide);
      end
      n0 = ind_rises;
      u_mst.data_phase(ack);
      chk("ack", ec != 0 || ei, ack);
      chk("indicator", (ec != 0 || ei) ? 1 : 0, ind_rises - n0);
   endtask : run_cycle

   task automatic end_test(input string nm);
      $display("test %s finished, mismatches so far %0d", nm, num_errors);
   endtask : end_test

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   // ================================================================
   // Sequence
   initial begin
      logic [31:0] a;
      void'($urandom(32'h28e5));
      repeat (16) @(posedge i_clk_sys);
      #1 i_resetn = 1'b1;
      repeat (3) @(posedge i_clk_sys);
      #1 chk("rst_irq", 7'h7F, o_irq_n);
      chk("rst_ack", 1'b1, o_access_indicator_n);
      chk("rst_ind", 1'b0, o_access_indicator);
      end_test("reset");
      // Every modifier code, base from either source
      for (int k = 0; k < 64; k++) begin
         i_base_sel = 1'($urandom);
         i_rotary    = 16'($urandom);
         i_ader_high = 8'($urandom);
         i_ader_low  = 8'($urandom);
         a = $urandom;
         a[31:16] = i_base_sel ? {i_ader_high, i_ader_low} : i_rotary;
         if (k[5]) a[31:24] = 8'h00;
         if (k == 32'h2F) a[23:19] = i_geo_addr;
         if (k % 3 == 0) a[16 + k % 8] = ~a[16 + k % 8];
         if (k % 2 == 0) a[15:0] = 16'($urandom_range(32'h07FC));
         a[0] = 1'b0;
         run_cycle(k[5:0], a, 1'($urandom), 1'($urandom), 1'b0);
      end
      end_test("modifiers");
      i_base_sel = 1'b1;
      i_rotary = 16'h1234;
      i_ader_high = 8'h56;
      i_ader_low = 8'h78;
      run_cycle(AM_A32_USR_DATA, 32'h5678_07FC, 1'b0, 1'b1, 1'b0);
      run_cycle(AM_A32_USR_DATA, 32'h5678_07FE, 1'b1, 1'b0, 1'b0);
      run_cycle(AM_A32_SUP_BLT, 32'h5678_07FE, 1'b0, 1'b1, 1'b0);
      run_cycle(AM_A32_SUP_DATA, 32'h1234_0010, 1'b0, 1'b0, 1'b0);
      i_base_sel = 1'b0;
      run_cycle(AM_A32_SUP_DATA, 32'h1234_0010, 1'b0, 1'b0, 1'b0);
      end_test("boundaries");
      i_chain_pos = 2'b10;
      i_iackin_n = 1'b0;
      foreach (mam[i]) run_cycle(mam[i], 32'hAA00_1006, !mam[i][1], 1'b1, 1'b0);
      run_cycle(AM_A24_SUP_BLT, 32'hAA00_0000, 1'b0, 1'b1, 1'b0);
      i_chain_pos = 2'b00;
      run_cycle(AM_A32_SUP_BLT, 32'hAA00_0000, 1'b0, 1'b1, 1'b0);
      end_test("multicast");
      i_event_trig = 6'd2;
      i_event_count = 6'd2;
      for (int l = 0; l < 8; l++) begin
         i_irq_level = 3'(l);
         repeat (3) @(posedge i_clk_sys);
         #1 chk("irq", l == 0 ? 7'h7F : 7'(~(32'h1 << (l - 1))), o_irq_n);
      end
      run_cycle(6'h00, 32'h0000_000E, 1'b0, 1'b0, 1'b1);
      run_cycle(6'h00, 32'h0000_0006, 1'b0, 1'b0, 1'b1);
      i_event_count = 6'd1;
      repeat (3) @(posedge i_clk_sys);
      #1 chk("irq_release", 7'h7F, o_irq_n);
      end_test("interrupter");
      tally_and_finish();
   end

   initial begin
      #100us;
      num_errors++;
      $display("CHECK FAILED watchdog expected finish seen hang");
      tally_and_finish();
   end
endmodule : vmsad_tb_top
`default_nettype wire
